// [hdl/scpa_core.sv]
/*
 * Stack check and program address generator: stack pointer upkeep with
 * overflow and underflow traps, pushed PC word format, and program space
 * addresses for code fetch, table access and remapped data reads.
 * Assumes a classic Wishbone master, and an execution unit and program
 * memory on the same clock that take results one cycle after a request.
 */
// Chosen here: register access over Wishbone and the placing of the registers.
// Behaviour
// - Stack pointer addresses next free word, post-increments on push, pre-decrements on pop.
// - Call pushes upper PC word with its top bits zero-extended.
// - Exception entry places status low byte above the PC upper part.
// - Stack limit bit zero reads and acts as zero once the limit register has been written.
// - Stack limit register holds no reset value.
// - Stack address above limit traps; push at equal limit does not.
// - Stack address below 0800h raises an underflow trap.
// - Table address is table page above the 16-bit effective address.
// - Table page top bit selects user or configuration space.
// - Remap address joins remap page with low effective-address bits.
// - Remap address top bit is held zero.
// - Remap ignores EA bit 15; address bit 15 is page bit zero.
// - Fetch and remap addresses have bit zero held zero.
// - Table accesses take any byte alignment and reads reach configuration space.
// - Remap is read-only, low word only; table access reaches whole word.
// - Remap happens only with enable bit set and EA top bit one.
// - Table writes to configuration space are refused.
// - Remap is suspended while a table access is in progress.
`include "scpa_consts.svh"

module scpa_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Stack side
	input wire scpa_pkg::scpa_stack_req_t stack_req_i,
	output scpa_pkg::scpa_stack_res_t stack_res_o,
	// Program space side
	input wire logic [23:0] fetch_pc_i,
	output logic [23:0] fetch_addr_o,
	input wire scpa_pkg::scpa_pgm_req_t pgm_req_i,
	input wire logic table_busy_i,
	output scpa_pkg::scpa_pgm_res_t pgm_res_o,
	output logic table_reject_o
);
	import scpa_pkg::*;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr == off);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
		input logic [1:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	logic [15:0] stack_pointer_reg;
	logic [15:0] stack_upper_bound_reg;
	logic [7:0] table_page_reg;
	logic [7:0] remap_page_reg;
	logic remap_window_enable;
	logic [1:0] trap_seen;
	logic ack;

	// Bus decode
	wire bus_go = wb_cyc_i & wb_stb_i & ~ack;
	wire bus_wr = bus_go & wb_we_i;
	wire wr_sp = bus_wr & hit(wb_adr_i, `SCPA_OFF_SP);
	wire wr_limit = bus_wr & hit(wb_adr_i, `SCPA_OFF_LIMIT);
	wire wr_table_page_reg = bus_wr & hit(wb_adr_i, `SCPA_OFF_TABLE_PAGE_REG) & wb_sel_i[0];
	wire wr_remap_page_reg = bus_wr & hit(wb_adr_i, `SCPA_OFF_REMAP_PAGE_REG) & wb_sel_i[0];
	wire wr_core = bus_wr & hit(wb_adr_i, `SCPA_OFF_CORE) & wb_sel_i[0];
	wire wr_status = bus_wr & hit(wb_adr_i, `SCPA_OFF_STATUS) & wb_sel_i[0];
	wire [15:0] core_word = {13'h0000, remap_window_enable, 2'h0};
	wire [15:0] rd_word =
		hit(wb_adr_i, `SCPA_OFF_SP) ? stack_pointer_reg :
		hit(wb_adr_i, `SCPA_OFF_LIMIT) ? stack_upper_bound_reg :
		hit(wb_adr_i, `SCPA_OFF_TABLE_PAGE_REG) ? {`SCPA_ZERO_BYTE, table_page_reg} :
		hit(wb_adr_i, `SCPA_OFF_REMAP_PAGE_REG) ? {`SCPA_ZERO_BYTE, remap_page_reg} :
		hit(wb_adr_i, `SCPA_OFF_CORE) ? core_word :
		hit(wb_adr_i, `SCPA_OFF_STATUS) ? {14'h0000, trap_seen} : 16'h0000;

	// Stack address generation
	wire op_push = stack_req_i.push & ~stack_req_i.pop;
	wire op_pop = stack_req_i.pop & ~stack_req_i.push;
	wire op_any = op_push | op_pop;
	wire [15:0] sp_dec = stack_pointer_reg - `SCPA_WORD_STEP;
	wire [15:0] sp_inc = stack_pointer_reg + `SCPA_WORD_STEP;
	wire [15:0] stack_ea = op_push ? stack_pointer_reg : sp_dec;
	wire next_overflow = op_any & (stack_ea > stack_upper_bound_reg);
	wire next_underflow = op_any & (stack_ea < `SCPA_STACK_FLOOR);
	wire [7:0] hi_byte = stack_req_i.exc_entry ? stack_req_i.status_low_byte : `SCPA_ZERO_BYTE;
	wire [15:0] next_pc_hi_word = {hi_byte, 1'b0, stack_req_i.pc[22:16]};
	wire [15:0] next_sp = op_push ? sp_inc : op_pop ? sp_dec :
		wr_sp ? (merge16(stack_pointer_reg, wb_dat_i[15:0], wb_sel_i[1:0]) & `SCPA_ALIGN_MASK) :
		stack_pointer_reg;

	// Program address generation
	wire tbl_op = pgm_req_i.table_read_op | pgm_req_i.table_write_op;
	wire tbl_cfg = table_page_reg[`SCPA_CFG_SPACE_BIT];
	wire tbl_refuse = pgm_req_i.table_write_op & tbl_cfg;
	wire remap_go = pgm_req_i.data_read & pgm_req_i.ea[`SCPA_EA_TOP_BIT] & remap_window_enable
		& ~tbl_op & ~table_busy_i;
	wire [23:0] tbl_addr = {table_page_reg, pgm_req_i.ea};
	wire [23:0] remap_addr = {1'b0, remap_page_reg, pgm_req_i.ea[14:1], 1'b0};
	// Enum is two-state, so it must be a variable rather than a net
	scpa_acc_t acc;
	assign acc = tbl_op ? SCPA_ACC_TABLE : remap_go ? SCPA_ACC_REMAP : SCPA_ACC_NONE;
	scpa_pgm_res_t next_pgm;
	always_comb begin
		next_pgm = '0;
		case (acc)
			SCPA_ACC_TABLE: begin
				next_pgm.valid = ~tbl_refuse;
				next_pgm.write = pgm_req_i.table_write_op;
				next_pgm.cfg_space = tbl_cfg;
				next_pgm.addr = tbl_addr;
			end
			SCPA_ACC_REMAP: begin
				next_pgm.valid = 1'b1;
				next_pgm.low_word_only = 1'b1;
				next_pgm.addr = remap_addr;
			end
			default: begin
				next_pgm = '0;
			end
		endcase
	end

	// Bus slave and control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			table_page_reg <= `SCPA_PAGE_RESET;
			remap_page_reg <= `SCPA_PAGE_RESET;
			remap_window_enable <= 1'b0;
		end else begin
			ack <= bus_go;
			wb_dat_o <= bus_go ? {16'h0000, rd_word} : 32'h0000_0000;
			if (wr_table_page_reg)
				table_page_reg <= wb_dat_i[7:0];
			if (wr_remap_page_reg)
				remap_page_reg <= wb_dat_i[7:0];
			if (wr_core)
				remap_window_enable <= wb_dat_i[`SCPA_REMAP_EN_BIT];
		end
	end
	assign wb_ack_o = ack;

	// Limit register has no reset on purpose
	always_ff @(posedge clk_i) begin
		if (wr_limit)
			stack_upper_bound_reg <= merge16(stack_upper_bound_reg, wb_dat_i[15:0], wb_sel_i[1:0])
				& `SCPA_ALIGN_MASK;
	end

	// Stack pointer, sticky trap flags and results
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_pointer_reg <= `SCPA_SP_RESET;
			trap_seen <= 2'b00;
			stack_res_o <= '0;
			pgm_res_o <= '0;
			table_reject_o <= 1'b0;
			fetch_addr_o <= 24'h000000;
		end else begin
			stack_pointer_reg <= next_sp;
			trap_seen <= (trap_seen & ~(wr_status ? wb_dat_i[1:0] : 2'b00)) | {next_underflow, next_overflow};
			stack_res_o.valid <= op_any;
			stack_res_o.addr <= stack_ea;
			stack_res_o.pc_hi_word <= next_pc_hi_word;
			stack_res_o.overflow <= next_overflow;
			stack_res_o.underflow <= next_underflow;
			pgm_res_o <= next_pgm;
			table_reject_o <= (acc == SCPA_ACC_TABLE) & tbl_refuse;
			fetch_addr_o <= {1'b0, fetch_pc_i[22:1], 1'b0};
		end
	end

	// Checks
	a_push_grows: assert property (@(posedge clk_i) disable iff (rst_i)
		op_push |=> stack_pointer_reg == $past(stack_pointer_reg) + `SCPA_WORD_STEP
			&& stack_res_o.addr == $past(stack_pointer_reg))
		else $error("push did not post-increment");
	a_pop_shrinks: assert property (@(posedge clk_i) disable iff (rst_i)
		op_pop |=> stack_res_o.addr == stack_pointer_reg
			&& stack_pointer_reg == $past(stack_pointer_reg) - `SCPA_WORD_STEP)
		else $error("pop did not pre-decrement");
	a_call_msb_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		op_any && !stack_req_i.exc_entry |=> stack_res_o.pc_hi_word[15:7] == 9'h000)
		else $error("call push upper bits not clear");
	a_exc_status_byte: assert property (@(posedge clk_i) disable iff (rst_i)
		op_any && stack_req_i.exc_entry |=>
			stack_res_o.pc_hi_word[15:8] == $past(stack_req_i.status_low_byte))
		else $error("exception push lacks status byte");
	a_limit_aligned: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(wr_limit) |-> stack_upper_bound_reg[0] == 1'b0)
		else $error("limit bit zero set");
	a_equal_no_trap: assert property (@(posedge clk_i) disable iff (rst_i)
		op_push && stack_pointer_reg == stack_upper_bound_reg
			|=> !stack_res_o.overflow ##0 stack_res_o.valid)
		else $error("trap at equal limit");
	a_next_push_traps: assert property (@(posedge clk_i) disable iff (rst_i)
		op_push && stack_pointer_reg == stack_upper_bound_reg + `SCPA_WORD_STEP
			&& stack_pointer_reg > stack_upper_bound_reg |=> stack_res_o.overflow)
		else $error("overflow push did not trap");
	a_underflow_trap: assert property (@(posedge clk_i) disable iff (rst_i)
		op_any && stack_ea < `SCPA_STACK_FLOOR |=> stack_res_o.underflow && stack_res_o.valid)
		else $error("underflow not trapped");
	a_trap_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		(stack_res_o.overflow || stack_res_o.underflow) |-> stack_res_o.valid && $past(op_any))
		else $error("trap without a stack address");
	a_table_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		tbl_op && !tbl_refuse |=> pgm_res_o.valid
			&& pgm_res_o.addr == {$past(table_page_reg), $past(pgm_req_i.ea)}
			&& pgm_res_o.cfg_space == $past(table_page_reg[7]))
		else $error("table address wrong");
	a_cfg_write_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		pgm_req_i.table_write_op && tbl_cfg |=> !pgm_res_o.valid && table_reject_o)
		else $error("configuration write not refused");
	a_remap_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		remap_go |=> pgm_res_o.valid && !pgm_res_o.write && pgm_res_o.low_word_only
			&& pgm_res_o.addr[23] == 1'b0 && pgm_res_o.addr[0] == 1'b0
			&& pgm_res_o.addr[15] == $past(remap_page_reg[0])
			&& pgm_res_o.addr[14:1] == $past(pgm_req_i.ea[14:1]))
		else $error("remap address wrong");
	a_remap_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		pgm_req_i.data_read && !tbl_op && (!remap_window_enable || !pgm_req_i.ea[15] || table_busy_i)
			|=> !pgm_res_o.valid)
		else $error("remap without permission");
	a_fetch_aligned: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> fetch_addr_o[0] == 1'b0 && fetch_addr_o[23] == 1'b0
			&& fetch_addr_o[22:1] == $past(fetch_pc_i[22:1]))
		else $error("fetch address wrong");
endmodule

// [inc/scpa_consts.svh]
/*
 * Constants for the stack check and program address generator: register
 * offsets, field positions, reset values and address limits.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef SCPA_CONSTS_SVH
`define SCPA_CONSTS_SVH

// Register word offsets on the Wishbone slave
`define SCPA_OFF_SP 8'h00
`define SCPA_OFF_LIMIT 8'h04
`define SCPA_OFF_TABLE_PAGE_REG 8'h08
`define SCPA_OFF_REMAP_PAGE_REG 8'h0C
`define SCPA_OFF_CORE 8'h10
`define SCPA_OFF_STATUS 8'h14

// Field positions
`define SCPA_REMAP_EN_BIT 2
`define SCPA_CFG_SPACE_BIT 7
`define SCPA_EA_TOP_BIT 15
`define SCPA_ST_OVF_BIT 0
`define SCPA_ST_UNF_BIT 1

// Address figures
`define SCPA_STACK_FLOOR 16'h0800
`define SCPA_WORD_STEP 16'h0002
`define SCPA_ALIGN_MASK 16'hFFFE
`define SCPA_ZERO_BYTE 8'h00

// Reset values
`define SCPA_SP_RESET 16'h0800
`define SCPA_PAGE_RESET 8'h00

`endif

// [inc/scpa_pkg.sv]
/*
 * Types for the stack check and program address generator.
 * Assumes the core and program memory sit on the same clock.
 */
package scpa_pkg;

	// Stack operation request from the execution unit
	typedef struct packed {
		logic push;
		logic pop;
		logic exc_entry;
		logic [23:0] pc;
		logic [7:0] status_low_byte;
	} scpa_stack_req_t;

	// Stack address result towards data memory and exception logic
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] pc_hi_word;
		logic overflow;
		logic underflow;
	} scpa_stack_res_t;

	// Program space access request from the execution unit
	typedef struct packed {
		logic table_read_op;
		logic table_write_op;
		logic data_read;
		logic [15:0] ea;
	} scpa_pgm_req_t;

	// Program memory access request
	typedef struct packed {
		logic valid;
		logic write;
		logic cfg_space;
		logic low_word_only;
		logic [23:0] addr;
	} scpa_pgm_res_t;

	typedef enum {SCPA_ACC_NONE, SCPA_ACC_TABLE, SCPA_ACC_REMAP} scpa_acc_t;

endpackage

// [tb/scpa_pmem_model.sv]
/*
 * Program memory model: counts the writes that reach the array, split into
 * user and configuration space.
 * Assumes requests from the generator on the same clock, one per cycle.
 */
module scpa_pmem_model
	import scpa_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Access from the generator
	input wire scpa_pkg::scpa_pgm_res_t pgm_res_i,
	// Write counts
	output logic [7:0] user_writes_o,
	output logic [7:0] cfg_writes_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			user_writes_o <= 8'h00;
			cfg_writes_o <= 8'h00;
		end else if (pgm_res_i.valid && pgm_res_i.write) begin
			if (pgm_res_i.cfg_space)
				cfg_writes_o <= cfg_writes_o + 8'h01;
			else
				user_writes_o <= user_writes_o + 8'h01;
		end
	end
endmodule

// [tb/scpa_core_bench.sv]
/*
 * Self-checking bench for the stack check and program address generator.
 * Assumes the design answers one cycle after each request.
 */
`include "scpa_consts.svh"
module scpa_core_bench;
	import scpa_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00, uw, cw;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	scpa_stack_req_t sreq = '0;
	scpa_stack_res_t sres;
	scpa_pgm_req_t preq = '0;
	scpa_pgm_res_t pres;
	logic [23:0] fpc = 24'h0, faddr;
	logic tbusy = 1'b0, rej;
	int mismatches = 0, total_checks = 0, cycles = 0;
	scpa_core scpa_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .stack_req_i(sreq), .stack_res_o(sres), .fetch_pc_i(fpc), .fetch_addr_o(faddr),
		.pgm_req_i(preq), .table_busy_i(tbusy), .pgm_res_o(pres), .table_reject_o(rej));
	scpa_pmem_model scpa_pmem_model_i (.clk_i(clk_i), .rst_i(rst_i), .pgm_res_i(pres),
		.user_writes_o(uw), .cfg_writes_o(cw));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic wrap_up();
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Op is push, pop, exception entry; pc upper part is 2B
	task automatic stk(input logic [2:0] op, input logic [15:0] ea, input logic [15:0] hi, input logic [1:0] fl);
		@(posedge clk_i);
		sreq <= {op, 24'hABCDEF, 8'h5A};
		@(posedge clk_i);
		sreq <= '0;
		#1;
		check({sres.valid, sres.addr, sres.overflow, sres.underflow}, {1'b1, ea, fl});
		if (op[2])
			check(sres.pc_hi_word, hi);
	endtask
	// Op is table read, table write, data read
	task automatic pg(input logic [2:0] op, input logic [15:0] ea, input logic busy, input logic [27:0] exp,
		input logic rj);
		@(posedge clk_i);
		preq <= {op, ea};
		tbusy <= busy;
		@(posedge clk_i);
		preq <= '0;
		tbusy <= 1'b0;
		#1;
		check(rej, rj);
		check(exp[27] ? pres : pres.valid, exp[27] ? exp : 28'h0);
	endtask
	task automatic t_stack();
		wb(1'b0, `SCPA_OFF_SP, 32'h0);
		check(q, 32'h0800);
		wb(1'b1, `SCPA_OFF_LIMIT, 32'h0803);
		wb(1'b0, `SCPA_OFF_LIMIT, 32'h0);
		check(q, 32'h0802);
		wb(1'b0, 8'h18, 32'h0);
		check(q, 32'h0);
		stk(3'b100, 16'h0800, 16'h002B, 2'b00);
		stk(3'b100, 16'h0802, 16'h002B, 2'b00);
		stk(3'b101, 16'h0804, 16'h5A2B, 2'b10);
		@(posedge clk_i);
		#1;
		check({sres.valid, sres.overflow}, 2'b00);
		wb(1'b0, `SCPA_OFF_SP, 32'h0);
		check(q, 32'h0806);
		stk(3'b010, 16'h0804, 16'h0, 2'b10);
		stk(3'b010, 16'h0802, 16'h0, 2'b00);
		stk(3'b010, 16'h0800, 16'h0, 2'b00);
		stk(3'b010, 16'h07FE, 16'h0, 2'b01);
		wb(1'b0, `SCPA_OFF_STATUS, 32'h0);
		check(q, 32'h3);
		wb(1'b1, `SCPA_OFF_STATUS, 32'h3);
		wb(1'b0, `SCPA_OFF_STATUS, 32'h0);
		check(q, 32'h0);
		wb(1'b0, `SCPA_OFF_SP, 32'h0);
		check(q, 32'h07FE);
	endtask
	task automatic t_prog();
		wb(1'b1, `SCPA_OFF_TABLE_PAGE_REG, 32'h12);
		wb(1'b1, `SCPA_OFF_REMAP_PAGE_REG, 32'h35);
		wb(1'b1, `SCPA_OFF_CORE, 32'h04);
		pg(3'b100, 16'h1235, 1'b0, {4'h8, 24'h121235}, 1'b0);
		pg(3'b010, 16'h0001, 1'b0, {4'hC, 24'h120001}, 1'b0);
		pg(3'b001, 16'h8ABD, 1'b0, {4'h9, 1'b0, 8'h35, 14'h055E, 1'b0}, 1'b0);
		pg(3'b001, 16'h0ABD, 1'b0, 28'h0, 1'b0);
		pg(3'b001, 16'h8ABD, 1'b1, 28'h0, 1'b0);
		pg(3'b101, 16'h8ABD, 1'b0, {4'h8, 24'h128ABD}, 1'b0);
		wb(1'b1, `SCPA_OFF_TABLE_PAGE_REG, 32'h92);
		pg(3'b100, 16'h0007, 1'b0, {4'hA, 24'h920007}, 1'b0);
		pg(3'b010, 16'h0007, 1'b0, 28'h0, 1'b1);
		wb(1'b1, `SCPA_OFF_REMAP_PAGE_REG, 32'hB4);
		pg(3'b001, 16'hFFFF, 1'b0, {4'h9, 1'b0, 8'hB4, 14'h3FFF, 1'b0}, 1'b0);
		wb(1'b1, `SCPA_OFF_CORE, 32'h00);
		pg(3'b001, 16'h8ABD, 1'b0, 28'h0, 1'b0);
		@(posedge clk_i);
		fpc <= 24'hFFFFFF;
		@(posedge clk_i);
		#1;
		check(faddr, 24'h7FFFFE);
		check({uw, cw}, 16'h0100);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_stack();
		t_prog();
		wrap_up();
	end
endmodule
